//--- verilog/pmsd_pkg.sv
`default_nettype none

package pmsd_pkg;

    localparam int VA_W = 64;
    localparam int TAG_W = 8;
    localparam int DATA_W = 32;
    localparam int ADDR_W = 32;
    localparam int CNT_W = 16;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] OFS_CTRL = 32'h0000_0000;
    localparam logic [ADDR_W-1:0] OFS_VADDR_LO = 32'h0000_0004;
    localparam logic [ADDR_W-1:0] OFS_VADDR_HI = 32'h0000_0008;
    localparam logic [ADDR_W-1:0] OFS_RESULT = 32'h0000_000c;
    localparam logic [ADDR_W-1:0] OFS_MISS_CNT = 32'h0000_0010;
    localparam logic [ADDR_W-1:0] OFS_ERR_CNT = 32'h0000_0014;
    localparam int REG_ADDR_LSB = 2;
    localparam int REG_ADDR_MSB = 7;

    // Control register fields
    localparam int CTRL_PRIV_LSB = 0;
    localparam int CTRL_EXC_LVL_BIT = 2;
    localparam int CTRL_ERR_LVL_BIT = 3;
    localparam int CTRL_USER_WIDE_BIT = 4;
    localparam int CTRL_SUPER_WIDE_BIT = 5;
    localparam int CTRL_KERN_WIDE_BIT = 6;
    localparam int CTRL_TAG_LSB = 8;

    // Result register fields
    localparam int RES_MODE_LSB = 0;
    localparam int RES_WIDE_BIT = 2;
    localparam int RES_SEG_LSB = 3;
    localparam int RES_ERR_BIT = 7;
    localparam int RES_MAPPED_BIT = 8;
    localparam int RES_EXT_BIT = 9;

    // Privilege field codes
    localparam logic [1:0] PRIV_USER = 2'h2;
    localparam logic [1:0] PRIV_SUPER = 2'h1;

    // Address pattern constants
    localparam int NARROW_SIGN_BIT = 31;
    localparam int USER_TOP_LSB = 40;
    localparam logic [2:0] SSSEG_TOP3 = 3'h6;
    localparam logic [1:0] WSEL_XSUSEG = 2'h0;
    localparam logic [1:0] WSEL_XSSEG = 2'h1;
    localparam logic [1:0] WSEL_CSSEG = 2'h3;

    localparam logic [DATA_W-1:0] RESET_WORD = 32'h0000_0000;
    localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;

    typedef enum logic [1:0] {
        MODE_USER,
        MODE_SUPER,
        MODE_KERNEL
    } pmsd_mode_e;

    typedef enum logic [3:0] {
        SEG_NONE,
        SEG_USEG,
        SEG_XUSEG,
        SEG_SUSEG,
        SEG_SSSEG,
        SEG_XSUSEG,
        SEG_XSSEG,
        SEG_CSSEG,
        SEG_KERNEL
    } pmsd_seg_e;

    typedef struct packed {
        logic [TAG_W-1:0] tag;
        logic kernel_wide_addressing;
        logic supervisor_wide_addressing;
        logic user_wide_addressing;
        logic error_level_flag;
        logic exception_level_flag;
        logic [1:0] priv;
    } pmsd_ctrl_s;

    typedef struct packed {
        logic mapped;
        logic [TAG_W-1:0] tag;
        logic [VA_W-1:0] vaddr;
    } pmsd_xlat_s;

    typedef struct packed {
        pmsd_mode_e mode;
        logic wide;
        pmsd_seg_e seg;
        logic addr_err;
        logic ext_vec;
        pmsd_xlat_s xlat;
    } pmsd_result_s;

endpackage : pmsd_pkg

`default_nettype wire

//--- verilog/pmsd_decode.sv
`timescale 1ns/10ps
`default_nettype none

module pmsd_decode
    import pmsd_pkg::*;
(
    input wire pmsd_ctrl_s ctrl,
    input wire logic [VA_W-1:0] vaddr,
    output pmsd_result_s res
);

    logic sext_ok;
    logic narrow_low;
    logic wide_low;
    logic mid_zero;
    logic cs_upper;

    assign sext_ok = (vaddr[VA_W-1:NARROW_SIGN_BIT+1] == {(VA_W-NARROW_SIGN_BIT-1){vaddr[NARROW_SIGN_BIT]}});
    assign narrow_low = sext_ok && !vaddr[NARROW_SIGN_BIT];
    assign wide_low = (vaddr[VA_W-1:USER_TOP_LSB] == '0);
    assign mid_zero = (vaddr[VA_W-3:USER_TOP_LSB] == '0);
    assign cs_upper = (vaddr[VA_W-3:NARROW_SIGN_BIT+1] == '1);

    always_comb begin
        res = '0;
        res.xlat.vaddr = vaddr;
        if (ctrl.priv == PRIV_USER && !ctrl.exception_level_flag && !ctrl.error_level_flag) begin
            res.mode = MODE_USER;
            res.wide = ctrl.user_wide_addressing;
        end else if (ctrl.priv == PRIV_SUPER && !ctrl.exception_level_flag && !ctrl.error_level_flag) begin
            res.mode = MODE_SUPER;
            res.wide = ctrl.supervisor_wide_addressing;
        end else begin
            res.mode = MODE_KERNEL;
            res.wide = ctrl.kernel_wide_addressing;
        end
        case (res.mode)
            MODE_USER: begin
                if (res.wide) begin
                    res.seg = wide_low ? SEG_XUSEG : SEG_NONE;
                end else begin
                    res.seg = narrow_low ? SEG_USEG : SEG_NONE;
                end
            end
            MODE_SUPER: begin
                if (!res.wide) begin
                    if (!sext_ok) begin
                        res.seg = SEG_NONE;
                    end else if (!vaddr[NARROW_SIGN_BIT]) begin
                        res.seg = SEG_SUSEG;
                    end else if (vaddr[NARROW_SIGN_BIT:NARROW_SIGN_BIT-2] == SSSEG_TOP3) begin
                        res.seg = SEG_SSSEG;
                    end else begin
                        res.seg = SEG_NONE;
                    end
                end else begin
                    case (vaddr[VA_W-1:VA_W-2])
                        WSEL_XSUSEG: res.seg = mid_zero ? SEG_XSUSEG : SEG_NONE;
                        WSEL_XSSEG: res.seg = mid_zero ? SEG_XSSEG : SEG_NONE;
                        WSEL_CSSEG: begin
                            if (cs_upper && vaddr[NARROW_SIGN_BIT:NARROW_SIGN_BIT-2] == SSSEG_TOP3) begin
                                res.seg = SEG_CSSEG;
                            end else begin
                                res.seg = SEG_NONE;
                            end
                        end
                        default: res.seg = SEG_NONE;
                    endcase
                end
            end
            default: begin
                // Kernel layout is not split further; outside the shared user segment every valid address is SEG_KERNEL
                if (!res.wide) begin
                    if (!sext_ok) begin
                        res.seg = SEG_NONE;
                    end else begin
                        res.seg = narrow_low ? SEG_USEG : SEG_KERNEL;
                    end
                end else begin
                    res.seg = wide_low ? SEG_XUSEG : SEG_KERNEL;
                end
            end
        endcase
        res.addr_err = (res.seg == SEG_NONE);
        res.xlat.mapped = !res.addr_err && (res.seg != SEG_KERNEL);
        res.xlat.tag = res.xlat.mapped ? ctrl.tag : '0;
        res.ext_vec = res.wide;
    end

endmodule : pmsd_decode

`default_nettype wire

//--- verilog/pmsd_top.sv
`timescale 1ns/10ps
`default_nettype none

// Notes on behaviour
// - Privilege from field and both level flags.
// - Each mode uses only its wide bit.
// - Narrow user needs address bit 31 clear.
// - Wide user needs bits 63..40 zero.
// - Narrow addressing requires bit 31 sign extension.
// - User miss picks refill by user width.
// - Supervisor miss picks refill by supervisor width.
// - Narrow user segment always goes through translation.
// - User segment at zero, same from all modes.
// - Supervisor narrow, bit 31 clear: user segment.
// - Supervisor narrow, top bits 110: supervisor segment.
// - Supervisor wide, top 00: wide user segment.
// - Supervisor wide, top 01: current supervisor segment.
// - Supervisor wide, top 11: separate supervisor segment.
// - Mapped references carry the address space tag.
// - Kernel miss picks refill by kernel width.
module pmsd_top
    import pmsd_pkg::*;
#(
    parameter int CNT_BITS = CNT_W
)
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [ADDR_W-1:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [DATA_W-1:0] hwdata,
    input wire logic hready,
    output logic [DATA_W-1:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic xlat_miss,
    output pmsd_xlat_s xlat_req,
    output logic addr_error,
    output logic refill_req,
    output logic refill_ext
);

    // Bus state
    logic rd_pend_ff;
    logic nxt_rd_pend;
    logic wr_pend_ff;
    logic nxt_wr_pend;
    logic [ADDR_W-1:0] dph_addr_ff;
    logic [ADDR_W-1:0] nxt_dph_addr;
    logic [DATA_W-1:0] hrdata_ff;
    logic [DATA_W-1:0] nxt_hrdata;
    logic accept;

    // Software-visible state
    pmsd_ctrl_s ctrl_ff;
    pmsd_ctrl_s nxt_ctrl;
    logic [DATA_W-1:0] va_lo_ff;
    logic [DATA_W-1:0] nxt_va_lo;
    logic [DATA_W-1:0] va_hi_ff;
    logic [DATA_W-1:0] nxt_va_hi;
    logic [CNT_BITS-1:0] miss_cnt_ff;
    logic [CNT_BITS-1:0] nxt_miss_cnt;
    logic [CNT_BITS-1:0] err_cnt_ff;
    logic [CNT_BITS-1:0] nxt_err_cnt;

    // Decode pipeline state
    pmsd_result_s dec_res;
    pmsd_result_s res_ff;
    pmsd_result_s nxt_res;
    logic refill_req_ff;
    logic nxt_refill_req;
    logic refill_ext_ff;
    logic nxt_refill_ext;
    logic err_seen_ff;
    logic nxt_err_seen;

    function automatic logic [DATA_W-1:0] pack_ctrl(input pmsd_ctrl_s c);
        logic [DATA_W-1:0] w;
        w = '0;
        w[CTRL_PRIV_LSB +: 2] = c.priv;
        w[CTRL_EXC_LVL_BIT] = c.exception_level_flag;
        w[CTRL_ERR_LVL_BIT] = c.error_level_flag;
        w[CTRL_USER_WIDE_BIT] = c.user_wide_addressing;
        w[CTRL_SUPER_WIDE_BIT] = c.supervisor_wide_addressing;
        w[CTRL_KERN_WIDE_BIT] = c.kernel_wide_addressing;
        w[CTRL_TAG_LSB +: TAG_W] = c.tag;
        return w;
    endfunction : pack_ctrl

    function automatic pmsd_ctrl_s unpack_ctrl(input logic [DATA_W-1:0] w);
        pmsd_ctrl_s c;
        c.priv = w[CTRL_PRIV_LSB +: 2];
        c.exception_level_flag = w[CTRL_EXC_LVL_BIT];
        c.error_level_flag = w[CTRL_ERR_LVL_BIT];
        c.user_wide_addressing = w[CTRL_USER_WIDE_BIT];
        c.supervisor_wide_addressing = w[CTRL_SUPER_WIDE_BIT];
        c.kernel_wide_addressing = w[CTRL_KERN_WIDE_BIT];
        c.tag = w[CTRL_TAG_LSB +: TAG_W];
        return c;
    endfunction : unpack_ctrl

    function automatic logic [DATA_W-1:0] pack_result(input pmsd_result_s r);
        logic [DATA_W-1:0] w;
        w = '0;
        w[RES_MODE_LSB +: 2] = r.mode;
        w[RES_WIDE_BIT] = r.wide;
        w[RES_SEG_LSB +: 4] = r.seg;
        w[RES_ERR_BIT] = r.addr_err;
        w[RES_MAPPED_BIT] = r.xlat.mapped;
        w[RES_EXT_BIT] = r.ext_vec;
        return w;
    endfunction : pack_result

    function automatic logic is_reg(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
        return a[REG_ADDR_MSB:REG_ADDR_LSB] == ofs[REG_ADDR_MSB:REG_ADDR_LSB]
            && a[ADDR_W-1:REG_ADDR_MSB+1] == '0;
    endfunction : is_reg

    pmsd_decode u_decode (
        .ctrl(ctrl_ff),
        .vaddr({va_hi_ff, va_lo_ff}),
        .res(dec_res)
    );

    // Only the read data phase waits one cycle, so hrdata can come from a flip-flop
    assign hreadyout = !rd_pend_ff;
    assign hresp = 1'b0;
    assign hrdata = hrdata_ff;
    assign accept = hsel && htrans[1] && hready;

    always_comb begin
        nxt_rd_pend = 1'b0;
        nxt_wr_pend = 1'b0;
        nxt_dph_addr = dph_addr_ff;
        nxt_hrdata = hrdata_ff;
        if (accept) begin
            nxt_dph_addr = haddr;
            nxt_rd_pend = !hwrite;
            nxt_wr_pend = hwrite;
        end
        if (rd_pend_ff) begin
            if (is_reg(dph_addr_ff, OFS_CTRL)) begin
                nxt_hrdata = pack_ctrl(ctrl_ff);
            end else if (is_reg(dph_addr_ff, OFS_VADDR_LO)) begin
                nxt_hrdata = va_lo_ff;
            end else if (is_reg(dph_addr_ff, OFS_VADDR_HI)) begin
                nxt_hrdata = va_hi_ff;
            end else if (is_reg(dph_addr_ff, OFS_RESULT)) begin
                nxt_hrdata = pack_result(res_ff);
            end else if (is_reg(dph_addr_ff, OFS_MISS_CNT)) begin
                nxt_hrdata = DATA_W'(miss_cnt_ff);
            end else if (is_reg(dph_addr_ff, OFS_ERR_CNT)) begin
                nxt_hrdata = DATA_W'(err_cnt_ff);
            end else begin
                nxt_hrdata = RESET_WORD;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_pend_ff <= 1'b0;
            wr_pend_ff <= 1'b0;
            dph_addr_ff <= '0;
            hrdata_ff <= RESET_WORD;
        end else begin
            rd_pend_ff <= nxt_rd_pend;
            wr_pend_ff <= nxt_wr_pend;
            dph_addr_ff <= nxt_dph_addr;
            hrdata_ff <= nxt_hrdata;
        end
    end

    // Register writes land at the end of the write data phase
    always_comb begin
        nxt_ctrl = ctrl_ff;
        nxt_va_lo = va_lo_ff;
        nxt_va_hi = va_hi_ff;
        if (wr_pend_ff) begin
            if (is_reg(dph_addr_ff, OFS_CTRL)) begin
                nxt_ctrl = unpack_ctrl(hwdata);
            end else if (is_reg(dph_addr_ff, OFS_VADDR_LO)) begin
                nxt_va_lo = hwdata;
            end else if (is_reg(dph_addr_ff, OFS_VADDR_HI)) begin
                nxt_va_hi = hwdata;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_ff <= '0;
            va_lo_ff <= RESET_WORD;
            va_hi_ff <= RESET_WORD;
        end else begin
            ctrl_ff <= nxt_ctrl;
            va_lo_ff <= nxt_va_lo;
            va_hi_ff <= nxt_va_hi;
        end
    end

    // Decode result is registered to keep the address path short
    always_comb begin
        nxt_res = dec_res;
        nxt_refill_req = 1'b0;
        nxt_refill_ext = refill_ext_ff;
        nxt_miss_cnt = miss_cnt_ff;
        nxt_err_cnt = err_cnt_ff;
        nxt_err_seen = res_ff.addr_err;
        if (xlat_miss && res_ff.xlat.mapped) begin
            // Handler choice follows the width bit of the current mode only
            nxt_refill_req = 1'b1;
            nxt_refill_ext = res_ff.ext_vec;
            nxt_miss_cnt = miss_cnt_ff + CNT_BITS'(CNT_ONE);
        end
        if (res_ff.addr_err && !err_seen_ff) begin
            // Counts entries into the error state, not cycles spent in it
            nxt_err_cnt = err_cnt_ff + CNT_BITS'(CNT_ONE);
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            res_ff <= '0;
            refill_req_ff <= 1'b0;
            refill_ext_ff <= 1'b0;
            miss_cnt_ff <= '0;
            err_cnt_ff <= '0;
            err_seen_ff <= 1'b0;
        end else begin
            res_ff <= nxt_res;
            refill_req_ff <= nxt_refill_req;
            refill_ext_ff <= nxt_refill_ext;
            miss_cnt_ff <= nxt_miss_cnt;
            err_cnt_ff <= nxt_err_cnt;
            err_seen_ff <= nxt_err_seen;
        end
    end

    assign xlat_req = res_ff.xlat;
    assign addr_error = res_ff.addr_err;
    assign refill_req = refill_req_ff;
    assign refill_ext = refill_ext_ff;

endmodule : pmsd_top

`default_nettype wire

//--- verif/pmsd_properties.sv
`timescale 1ns/10ps
`default_nettype none
module pmsd_properties
    import pmsd_pkg::*;
#(
    parameter int CNT_BITS = CNT_W
)
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [ADDR_W-1:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [DATA_W-1:0] hwdata,
    input wire logic hready,
    input wire logic [DATA_W-1:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic xlat_miss,
    input wire pmsd_xlat_s xlat_req,
    input wire logic addr_error,
    input wire logic refill_req,
    input wire logic refill_ext
);
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    logic go;
    assign go = hsel && htrans[1] && hready;
    a_read_wait: assert property (go && !hwrite |=> !hreadyout ##1 hreadyout)
        else $error("read data phase length wrong");
    a_write_nowait: assert property (go && hwrite |=> hreadyout)
        else $error("write data phase stalled");
    a_okay_resp: assert property (hresp == 1'b0)
        else $error("response not okay");
    a_rdata_hold: assert property ($changed(hrdata) |-> !$past(hreadyout))
        else $error("read data changed outside a read");
    a_refill_taken: assert property (xlat_miss && xlat_req.mapped |=> refill_req)
        else $error("mapped miss gave no refill");
    a_refill_refused: assert property (xlat_miss && !xlat_req.mapped |=> !refill_req)
        else $error("unmapped miss gave a refill");
    a_refill_quiet: assert property (!xlat_miss |=> !refill_req)
        else $error("refill without a miss");
    a_ext_hold: assert property (!refill_req |-> $stable(refill_ext))
        else $error("refill vector changed without refill");
    a_tag_unmapped: assert property (!xlat_req.mapped |-> xlat_req.tag == '0)
        else $error("tag on unmapped reference");
    a_err_unmapped: assert property (addr_error |-> !xlat_req.mapped)
        else $error("faulting reference marked mapped");
    c_read: cover property (go && !hwrite);
    c_refill: cover property (refill_req && refill_ext);
    c_error: cover property ($rose(addr_error));
endmodule : pmsd_properties
bind pmsd_top pmsd_properties #(.CNT_BITS(CNT_BITS)) u_props (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .xlat_miss(xlat_miss), .xlat_req(xlat_req),
    .addr_error(addr_error), .refill_req(refill_req), .refill_ext(refill_ext));
`default_nettype wire

//--- verif/pmsd_xlat_model.sv
`timescale 1ns/10ps
`default_nettype none
module pmsd_xlat_model
    import pmsd_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic lookup,
    input wire logic force_miss,
    input wire logic slow,
    input wire pmsd_xlat_s xlat_req,
    input wire logic refill_req,
    output logic xlat_miss,
    output logic [15:0] refills
);
    logic hit_go;
    logic [1:0] pend;
    // Real buffers never see unmapped references; force is a deliberate fault
    assign hit_go = lookup && (xlat_req.mapped || force_miss);
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pend <= 2'h0;
            xlat_miss <= 1'b0;
            refills <= 16'h0000;
        end else begin
            pend <= {pend[0], hit_go};
            xlat_miss <= slow ? pend[1] : hit_go;
            refills <= refills + {15'h0000, refill_req};
        end
    end
endmodule : pmsd_xlat_model
`default_nettype wire

//--- verif/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top
    import pmsd_pkg::*;
();
    localparam int N = 25;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [ADDR_W-1:0] haddr = '0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [DATA_W-1:0] hwdata = '0;
    logic lookup = 1'b0;
    logic force_miss = 1'b0;
    logic slow = 1'b0;
    logic [DATA_W-1:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic xlat_miss;
    pmsd_xlat_s xlat_req;
    logic addr_error;
    logic refill_req;
    logic refill_ext;
    logic [15:0] refills;
    logic [15:0] exp_miss = 16'h0000;
    int bad_count = 0;
    int num_checks = 0;
    logic [31:0] t_ctl [N] = '{32'h5a62, 32'h5a02, 32'h5a02, 32'h5a12, 32'h5a12, 32'h5a51, 32'h5a01,
        32'h5a01, 32'h5a01, 32'h5a01, 32'h5a21, 32'h5a21, 32'h5a21, 32'h5a21, 32'h5a21, 32'h5a21,
        32'h5a21, 32'h5a21, 32'h5a30, 32'h5a06, 32'h5a0a, 32'h5a03, 32'h5a40, 32'h5a00, 32'h5a05};
    logic [63:0] t_va [N] = '{64'h7fff_fffc, 64'hffff_ffff_8000_0000, 64'h1_0000_0000, 64'hff_ffff_fff0,
        64'h100_0000_0000, 64'h1234_5678, 64'hffff_ffff_c000_0000, 64'hffff_ffff_dfff_fffc,
        64'hffff_ffff_e000_0000, 64'hffff_ffff_8000_0000, 64'hff_ffff_ffff, 64'h4000_0000_0000_0000,
        64'h4000_00ff_ffff_ffff, 64'hffff_ffff_c000_0000, 64'hffff_ffff_dfff_ffff, 64'h8000_0000_0000_0000,
        64'h4000_0100_0000_0000, 64'hffff_ffff_e000_0000, 64'h1000, 64'h1000, 64'hffff_ffff_8000_0000,
        64'hffff_ffff_8000_0000, 64'hff_0000_0000, 64'h8000_0000, 64'h1000};
    // Expected {ext, mapped, error, segment, wide, mode}
    logic [9:0] t_exp [N] = '{10'h108, 10'h080, 10'h080, 10'h314, 10'h084, 10'h119, 10'h121, 10'h121,
        10'h081, 10'h081, 10'h32d, 10'h335, 10'h335, 10'h33d, 10'h33d, 10'h085, 10'h085, 10'h085,
        10'h10a, 10'h10a, 10'h042, 10'h042, 10'h316, 10'h082, 10'h10a};

    pmsd_top DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .xlat_miss(xlat_miss), .xlat_req(xlat_req),
        .addr_error(addr_error), .refill_req(refill_req), .refill_ext(refill_ext));
    pmsd_xlat_model u_far (.hclk(hclk), .hresetn(hresetn), .lookup(lookup), .force_miss(force_miss),
        .slow(slow), .xlat_req(xlat_req), .refill_req(refill_req), .xlat_miss(xlat_miss), .refills(refills));

    always #2 hclk = ~hclk;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // Ready is judged mid-cycle so the edge that follows is the one it is sampled at
    task automatic wait_rdy(output logic [31:0] q);
        int n;
        n = 0;
        @(negedge hclk);
        while (hreadyout !== 1'b1 && n < 50) begin
            n++;
            @(negedge hclk);
        end
        if (n == 50) begin
            bad_count++;
            close_out();
        end
        q = hrdata;
        @(posedge hclk);
    endtask : wait_rdy

    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        wait_rdy(q);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy(q);
    endtask : bus

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask : wr

    task automatic rd(input logic [31:0] a, output logic [31:0] q);
        bus(1'b0, a, 32'h0, q);
    endtask : rd

    task automatic run_case(input int i);
        logic [31:0] q;
        logic [9:0] e;
        e = t_exp[i];
        wr(OFS_CTRL, t_ctl[i]);
        wr(OFS_VADDR_LO, t_va[i][31:0]);
        wr(OFS_VADDR_HI, t_va[i][63:32]);
        rd(OFS_RESULT, q);
        check({q[31:10], q[9] & e[8], q[8:0]}, {22'h0, e}, "result");
        @(negedge hclk);
        check({31'h0, addr_error}, {31'h0, e[7]}, "addr_error");
        check({23'h0, xlat_req.mapped, xlat_req.tag}, {23'h0, e[8], e[8] ? t_ctl[i][15:8] : 8'h00}, "tag");
        check(xlat_req.vaddr[31:0], t_va[i][31:0], "vaddr lo");
        check(xlat_req.vaddr[63:32], t_va[i][63:32], "vaddr hi");
        @(posedge hclk);
        lookup <= 1'b1;
        force_miss <= !e[8];
        slow <= i[0];
        @(posedge hclk);
        lookup <= 1'b0;
        repeat (5) @(posedge hclk);
        @(negedge hclk);
        exp_miss += {15'h0, e[8]};
        check({16'h0, refills}, {16'h0, exp_miss}, "refills");
        if (e[8]) check({31'h0, refill_ext}, {31'h0, e[9]}, "refill_ext");
        $display("case %0d done", i);
    endtask : run_case

    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : close_out

    initial begin
        logic [31:0] q;
        logic [31:0] q0;
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        rd(OFS_CTRL, q);
        check(q, RESET_WORD, "ctrl reset");
        rd(OFS_RESULT, q);
        check(q, 32'h0000_010a, "result reset");
        wr(OFS_CTRL, 32'hffff_ffff);
        rd(OFS_CTRL, q);
        check(q, 32'h0000_ff7f, "ctrl fields");
        wr(OFS_RESULT, 32'hffff_ffff);
        rd(OFS_RESULT, q);
        check(q, 32'h0000_0316, "result read only");
        wr(32'h0000_0100, 32'hffff_ffff);
        rd(32'h0000_0100, q);
        check(q, 32'h0, "unmapped read");
        $display("register test done");
        for (int i = 0; i < N; i++) begin
            run_case(i);
        end
        rd(OFS_MISS_CNT, q);
        check(q, {16'h0, exp_miss}, "miss count");
        $display("miss count test done");
        rd(OFS_ERR_CNT, q0);
        wr(OFS_VADDR_HI, 32'h0000_0001);
        wr(OFS_VADDR_HI, 32'h0000_0000);
        rd(OFS_ERR_CNT, q);
        check(q, q0 + 32'h0000_0001, "error count");
        $display("error count test done");
        close_out();
    end

    // About 550 cycles expected; the 5000-cycle limit is more than eight times that
    initial begin
        #20000;
        bad_count++;
        close_out();
    end
endmodule : tb_top
`default_nettype wire
